/* File: core/efp_pkg.sv */
// Shared constants, types and helpers for the error flag port block.
package efp_pkg;

	// ==========================================================
	// Flag layout
	// ==========================================================
	localparam int GRP_W = 5;
	localparam int NFLAGS = 15;
	localparam int FF_LSB = 0;
	localparam int AP_LSB = 5;
	localparam int ANC_LSB = 10;
	localparam int VAL_W = 2;
	localparam int APV_BIT = 1;
	localparam int FFV_BIT = 0;

	// ==========================================================
	// Group select codes
	// ==========================================================
	localparam logic [1:0] SEL_FF = 2'h0;
	localparam logic [1:0] SEL_AP = 2'h1;
	localparam logic [1:0] SEL_ANC = 2'h2;
	localparam logic [1:0] SEL_CTL = 2'h3;

	// Control group bit positions on the five flag lines.
	localparam int CTL_INOUT_BIT = 4;
	localparam int CTL_CHK_BIT = 4;
	localparam int CTL_APV_BIT = 3;
	localparam int CTL_FFV_BIT = 2;
	localparam int CTL_S_BIT = 1;

	// ==========================================================
	// APB register map
	// ==========================================================
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_HOST_OVR = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam logic [11:0] ADDR_IN_FLAGS = 12'h00C;
	localparam int CTRL_BYPASS_BIT = 0;
	localparam int CTRL_HOST_EN_BIT = 1;
	localparam int HOVR_VAL_LSB = 15;
	localparam int STAT_INOUT_BIT = 15;
	localparam int STAT_BYPASS_BIT = 16;
	localparam int STAT_FWD_BIT = 17;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [16:0] HOST_OVR_RST = 17'h00000;
	localparam logic INOUT_RST = 1'b0;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam logic FWD_HOLD_LAST = 1'b1;
	localparam int LINK_MARGIN_CYC = 15;

	// Forwarding sequencer states.
	typedef enum logic [1:0] {
		FWD_IDLE = 2'b00,
		FWD_AP = 2'b01,
		FWD_FF = 2'b10,
		FWD_ANC = 2'b11
	} efp_fwd_t;

	// Picks one five-bit error group out of the fifteen flags.
	function automatic logic [GRP_W-1:0] efp_group(
		input logic [NFLAGS-1:0] flags,
		input logic [1:0] sel
	);
		logic [GRP_W-1:0] g;
		g = '0;
		case (sel)
			SEL_FF: g = flags[FF_LSB +: GRP_W];
			SEL_AP: g = flags[AP_LSB +: GRP_W];
			SEL_ANC: g = flags[ANC_LSB +: GRP_W];
			default: g = '0;
		endcase
		return g;
	endfunction

endpackage

/* File: core/efp_ovr_slot.sv */
// One-shot overwrite slot: holds a value until the next outgoing packet.
`timescale 1ns/10ps
module efp_ovr_slot #(
	parameter int W = 5
) (
	// Clock and control.
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Load from the flag port and consume by the packet.
	input wire logic load,
	input wire logic [W-1:0] load_val,
	input wire logic consume,
	// Stored overwrite.
	output logic pending,
	output logic [W-1:0] value
);

	// ==========================================================
	// Storage
	// ==========================================================
	// A load in the same cycle as the consume wins, so a write landing
	// on the packet edge applies to the following packet instead.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pending <= 1'b0;
			value <= '0;
		end else if (clk_en) begin
			if (load) begin
				pending <= 1'b1;
				value <= load_val;
			end else if (consume) begin
				pending <= 1'b0;
			end
		end
	end

endmodule

/* File: core/efp_flag_port.sv */
// Five-bit synchronous error flag port with forwarding and bypass modes.
//
// Contract
// R1: Other party starts write by lowering direction.
// R2: First low sample releases the flag lines.
// R3: Later low edges capture select and flags.
// R4: Write updates only the selected group.
// R5: Other waits one clock before driving flags.
// R6: High direction sample is read, select captured.
// R7: Selected group appears one clock after select.
// R8: CRC-only passes flags, recomputes packet CRC.
// R9: CRC-only overrides receive/transmit select input.
// R10: Other raises direction before forward input.
// R11: Forwarding drives flags and select after delay.
// R12: Forwarding steps select itself, presents flags.
// R13: Each forwarded value stands two clocks.
// R14: Forward select order 01,00,10, never 11.
// R15: Between packets show 01 with ancillary flags.
// R16: Bypass makes forwarded flags all zero.
// R17: Other keeps link latency under field minus 15.
// R18: Port overwrites beat host table overwrites.
// R19: Receiver in write mode inserts forwarded flags.
// R20: Bypass by pin or bit; overwrites ignored.
// R21: Bypass keeps incoming reads, outgoing reads zero.
// R22: Five lines reach fifteen flags in groups.
// R23: Port write affects only next outgoing packet.
// R24: Source select bit latched, cleared at reset.
// R25: Explicit output enable, released during writes.
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module efp_flag_port
	import efp_pkg::*;
(
	// Clock, reset and clock enable.
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Flag port pins.
	input wire logic port_read_nwrite,
	input wire logic flag_forward,
	input wire logic [1:0] group_sel_in,
	output logic [1:0] group_sel_out,
	output logic group_sel_oe_n,
	input wire logic [GRP_W-1:0] flag_lines_in,
	output logic [GRP_W-1:0] flag_lines_out,
	output logic flag_lines_oe_n,
	// Mode pins.
	input wire logic crc_only,
	input wire logic rx_tx_sel,
	input wire logic packet_processing_bypass,
	// Packet engine side.
	input wire logic packet_received,
	input wire logic packet_send,
	input wire logic [NFLAGS-1:0] in_flags,
	input wire logic [VAL_W-1:0] in_validity,
	input wire logic [NFLAGS-1:0] calc_flags,
	input wire logic packet_checksum_error,
	output logic [NFLAGS-1:0] out_flags,
	output logic [VAL_W-1:0] out_validity,
	output logic crc_replace
);

	// ==========================================================
	// Reset synchroniser
	// ==========================================================
	logic rst_meta_r; // First stage, read only by the second.
	logic rst_sync_n; // Released reset used everywhere else.

	// Release is delayed two edges so every flop leaves reset together.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_r <= 1'b0;
			rst_sync_n <= 1'b0;
		end else if (clk_en) begin
			rst_meta_r <= 1'b1;
			rst_sync_n <= rst_meta_r;
		end
	end

	// ==========================================================
	// APB registers
	// ==========================================================
	logic [1:0] ctrl_r; // Bypass bit and host overwrite enable.
	logic [16:0] host_ovr_r; // Host flags [14:0] and validity [16:15].
	logic in_out_sel_r; // Port reads: high incoming, low outgoing.
	logic fwd_on_r; // Forwarding drive enabled.
	logic bypass; // Effective bypass.
	logic host_en; // Host overwrite enabled.
	logic apb_setup; // Setup phase of a transfer.
	logic apb_wr; // Write access completes this edge.
	logic addr_ok; // Address is mapped.
	logic [31:0] rd_mux; // Read data selected by address.

	assign bypass = packet_processing_bypass | ctrl_r[CTRL_BYPASS_BIT]; // R20
	assign host_en = ctrl_r[CTRL_HOST_EN_BIT];
	assign apb_setup = psel & ~penable;
	assign apb_wr = psel & penable & pwrite & addr_ok;
	// No wait states; a frozen clock holds the access phase.
	assign pready = clk_en;
	assign pslverr = psel & penable & ~addr_ok;

	// Address decode and read multiplexer.
	always_comb begin
		addr_ok = 1'b1;
		rd_mux = 32'h00000000;
		case (paddr)
			ADDR_CTRL: rd_mux[1:0] = ctrl_r;
			ADDR_HOST_OVR: rd_mux[16:0] = host_ovr_r;
			ADDR_STATUS: begin
				// Outgoing flags read as zero in bypass.
				rd_mux[NFLAGS-1:0] = bypass ? '0 : out_flags; // R21
				rd_mux[STAT_INOUT_BIT] = in_out_sel_r;
				rd_mux[STAT_BYPASS_BIT] = bypass;
				rd_mux[STAT_FWD_BIT] = fwd_on_r;
			end
			ADDR_IN_FLAGS: rd_mux[NFLAGS-1:0] = in_flags; // R21
			default: addr_ok = 1'b0;
		endcase
	end

	// Register writes take effect at the access edge only.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ctrl_r <= CTRL_RST;
			host_ovr_r <= HOST_OVR_RST;
		end else if (clk_en && apb_wr) begin
			if (paddr == ADDR_CTRL) begin
				ctrl_r <= pwdata[1:0];
			end
			if (paddr == ADDR_HOST_OVR) begin
				host_ovr_r <= pwdata[16:0];
			end
		end
	end

	// Read data is latched in the setup phase and stands in access.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			prdata <= 32'h00000000;
		end else if (clk_en && apb_setup) begin
			prdata <= pwrite ? 32'h00000000 : rd_mux;
		end
	end

	// ==========================================================
	// Flag port write capture
	// ==========================================================
	logic wr_active_r; // Lines released, later edges capture.
	logic wr_capture; // This edge latches select and flags.
	logic [2:0] grp_load; // Per-group load strobes.
	logic [2:0] grp_pend; // Per-group overwrite pending.
	logic [NFLAGS-1:0] port_vals; // Stored port overwrite values.
	logic val_pend; // Validity overwrite pending.
	logic [VAL_W-1:0] val_port; // Stored validity overwrite.
	logic consume; // Outgoing packet takes the overwrites.

	assign wr_capture = ~port_read_nwrite & wr_active_r; // R3
	assign consume = packet_send;

	// The first low sample only releases the lines; data follow later.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			wr_active_r <= 1'b0;
		end else if (clk_en) begin
			wr_active_r <= ~port_read_nwrite; // R2
		end
	end

	// Each group gets its own strobe so others stay untouched.
	always_comb begin
		grp_load = 3'h0;
		if (wr_capture) begin
			case (group_sel_in)
				SEL_FF: grp_load[0] = 1'b1; // R4
				SEL_AP: grp_load[1] = 1'b1; // R4
				SEL_ANC: grp_load[2] = 1'b1; // R4
				default: grp_load = 3'h0;
			endcase
		end
	end

	// Three error groups held as one-shot overwrites.
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_grp
			efp_ovr_slot #(
				.W(GRP_W)
			) u_slot (
				.clk(clk),
				.rst_n(rst_sync_n),
				.clk_en(clk_en),
				.load(grp_load[gi]),
				.load_val(flag_lines_in),
				.consume(consume), // R23
				.pending(grp_pend[gi]),
				.value(port_vals[gi*GRP_W +: GRP_W])
			);
		end
	endgenerate

	// Validity bits share the control group write.
	efp_ovr_slot #(
		.W(VAL_W)
	) u_val_slot (
		.clk(clk),
		.rst_n(rst_sync_n),
		.clk_en(clk_en),
		.load(wr_capture && group_sel_in == SEL_CTL),
		.load_val({flag_lines_in[CTL_APV_BIT], flag_lines_in[CTL_FFV_BIT]}),
		.consume(consume),
		.pending(val_pend),
		.value(val_port)
	);

	// The source select bit persists until rewritten.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			in_out_sel_r <= INOUT_RST; // R24
		end else if (clk_en && wr_capture && group_sel_in == SEL_CTL) begin
			in_out_sel_r <= flag_lines_in[CTL_INOUT_BIT]; // R24
		end
	end

	// ==========================================================
	// Outgoing flag merge
	// ==========================================================
	logic [NFLAGS-1:0] base_flags; // Flags before any overwrite.
	logic [NFLAGS-1:0] host_flags; // After host overwrite.
	logic [NFLAGS-1:0] merged; // After flag port overwrite.
	logic [VAL_W-1:0] merged_val; // Outgoing validity.

	// Priority, lowest first: computed, host tables, flag port.
	always_comb begin
		if (crc_only) begin
			base_flags = in_flags; // R8 R9
		end else if (rx_tx_sel) begin
			base_flags = in_flags | calc_flags;
		end else begin
			base_flags = calc_flags;
		end
		host_flags = host_en ? host_ovr_r[NFLAGS-1:0] : base_flags;
		for (int g = 0; g < 3; g++) begin
			merged[g*GRP_W +: GRP_W] = grp_pend[g] ?
				port_vals[g*GRP_W +: GRP_W] :
				host_flags[g*GRP_W +: GRP_W]; // R18 R19
		end
		merged_val = host_en ? host_ovr_r[HOVR_VAL_LSB +: VAL_W] :
			in_validity;
		if (val_pend) begin
			merged_val = val_port; // R18
		end
	end

	// The packet edge loads the outgoing flags; bypass passes them raw.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			out_flags <= '0;
			out_validity <= '0;
			crc_replace <= 1'b0;
		end else if (clk_en && packet_send) begin
			out_flags <= bypass ? in_flags : merged; // R20
			out_validity <= bypass ? in_validity : merged_val; // R20
			crc_replace <= ~bypass; // R8
		end
	end

	// ==========================================================
	// Flag forwarding sequencer
	// ==========================================================
	efp_fwd_t fwd_state_r; // Current forwarded group.
	logic fwd_hold_r; // Second cycle of a forwarded value.
	logic [NFLAGS-1:0] fwd_flags_r; // Flags of the latest packet.
	logic fwd_req; // Forwarding requested at the pins.

	// The direction must already be high; a write cycle never forwards.
	assign fwd_req = flag_forward & port_read_nwrite;

	// The drive enable rises one edge after the request is seen; the pins drive one edge later.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			fwd_on_r <= 1'b0;
		end else if (clk_en) begin
			fwd_on_r <= fwd_req; // R11
		end
	end

	// A packet snapshot feeds the sequence; bypass forwards zeros.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			fwd_flags_r <= '0;
		end else if (clk_en && packet_received) begin
			fwd_flags_r <= bypass ? '0 : merged; // R16
		end
	end

	// Steps AP, FF, ANC with two cycles each, then rests.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			fwd_state_r <= FWD_IDLE;
			fwd_hold_r <= 1'b0;
		end else if (clk_en) begin
			case (fwd_state_r)
				FWD_IDLE: begin
					fwd_hold_r <= 1'b0;
					if (fwd_req && packet_received) begin
						fwd_state_r <= FWD_AP; // R12 R15
					end
				end
				FWD_AP, FWD_FF, FWD_ANC: begin
					fwd_hold_r <= ~fwd_hold_r; // R13
					if (fwd_hold_r == FWD_HOLD_LAST) begin
						case (fwd_state_r)
							FWD_AP: fwd_state_r <= FWD_FF; // R14
							FWD_FF: fwd_state_r <= FWD_ANC; // R14
							default: fwd_state_r <= FWD_IDLE;
						endcase
					end
				end
				default: fwd_state_r <= FWD_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Pin drivers
	// ==========================================================
	logic [GRP_W-1:0] rd_data; // Read group for the captured select.
	logic [GRP_W-1:0] fwd_data; // Forwarded group for the state.
	logic [1:0] fwd_sel; // Forwarded select value.

	// The read group comes from incoming or outgoing flags.
	always_comb begin
		rd_data = '0;
		if (group_sel_in == SEL_CTL) begin
			rd_data[CTL_CHK_BIT] = packet_checksum_error;
			rd_data[CTL_APV_BIT] = in_validity[APV_BIT];
			rd_data[CTL_FFV_BIT] = in_validity[FFV_BIT];
			rd_data[CTL_S_BIT] = in_out_sel_r; // R22
		end else if (in_out_sel_r) begin
			rd_data = efp_group(in_flags, group_sel_in); // R21 R22
		end else if (!bypass) begin
			rd_data = efp_group(out_flags, group_sel_in); // R22
		end
	end

	// Idle shows select 01 while the lines carry the ancillary group.
	always_comb begin
		case (fwd_state_r)
			FWD_AP: fwd_sel = SEL_AP;
			FWD_FF: fwd_sel = SEL_FF;
			FWD_ANC: fwd_sel = SEL_ANC;
			default: fwd_sel = SEL_AP; // R15
		endcase
		if (fwd_state_r == FWD_IDLE) begin
			fwd_data = efp_group(fwd_flags_r, SEL_ANC); // R15
		end else begin
			fwd_data = efp_group(fwd_flags_r, fwd_sel); // R12
		end
	end

	// Data and enables are registered; enables are active low.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			flag_lines_out <= '0;
			flag_lines_oe_n <= 1'b1;
			group_sel_out <= SEL_AP;
			group_sel_oe_n <= 1'b1;
		end else if (clk_en) begin
			flag_lines_oe_n <= ~port_read_nwrite; // R2 R25
			group_sel_oe_n <= ~fwd_on_r; // R11
			group_sel_out <= fwd_sel;
			if (fwd_on_r) begin
				flag_lines_out <= fwd_data; // R11
			end else if (port_read_nwrite) begin
				flag_lines_out <= rd_data; // R6 R7
			end
		end
	end

	// ==========================================================
	// Checks
	// ==========================================================
	sequence seq_fwd_walk;
		(group_sel_out == SEL_AP)[*2] ##1 (group_sel_out == SEL_FF)[*2]
			##1 (group_sel_out == SEL_ANC)[*2];
	endsequence

	sequence seq_fwd_start;
		fwd_on_r && fwd_req && fwd_state_r == FWD_IDLE && packet_received;
	endsequence

	AST_RELEASE: assert property (@(posedge clk) // R2
		disable iff (!rst_sync_n || !clk_en)
		(!port_read_nwrite && !wr_active_r) |=> flag_lines_oe_n)
		else $error("flag lines not released on write");

	AST_GROUP_ONLY: assert property (@(posedge clk) // R4
		disable iff (!rst_sync_n || !clk_en)
		(wr_capture && group_sel_in == SEL_FF && !packet_send) |=>
			grp_pend[0] && port_vals[4:0] == $past(flag_lines_in)
			&& $stable(port_vals[NFLAGS-1:AP_LSB]))
		else $error("flag write touched the wrong group");

	AST_READ_LATENCY: assert property (@(posedge clk) // R7
		disable iff (!rst_sync_n || !clk_en)
		(port_read_nwrite && !fwd_on_r && in_out_sel_r
			&& group_sel_in == SEL_ANC) |=>
			!flag_lines_oe_n && flag_lines_out == $past(in_flags[14:10]))
		else $error("read group late or wrong");

	// The registered select still shows the idle value one cycle after
	// the start, so the walk is checked from the second cycle on.
	AST_FWD_ORDER: assert property (@(posedge clk) // R13 R14
		disable iff (!rst_sync_n || !clk_en)
		seq_fwd_start |-> ##2 seq_fwd_walk ##1 (fwd_state_r == FWD_IDLE))
		else $error("forward sequence order or hold wrong");

	AST_FWD_IDLE: assert property (@(posedge clk) // R15
		disable iff (!rst_sync_n || !clk_en)
		(fwd_on_r && fwd_state_r == FWD_IDLE && $stable(fwd_flags_r))
			|=> group_sel_out == SEL_AP
			&& flag_lines_out == $past(fwd_flags_r[14:10]))
		else $error("idle forward output wrong");

	AST_FWD_BYPASS: assert property (@(posedge clk) // R16
		disable iff (!rst_sync_n || !clk_en)
		(packet_received && bypass) |=> fwd_flags_r == '0)
		else $error("bypass forwarded nonzero flags");

	AST_PORT_WINS: assert property (@(posedge clk) // R18 R23
		disable iff (!rst_sync_n || !clk_en)
		(packet_send && !bypass && grp_pend[0] && !wr_capture) |=>
			out_flags[4:0] == $past(port_vals[4:0]) && !grp_pend[0])
		else $error("port overwrite lost or kept");

	AST_CRC_ONLY: assert property (@(posedge clk) // R8 R9
		disable iff (!rst_sync_n || !clk_en)
		(packet_send && crc_only && !bypass && !host_en && grp_pend == 3'h0)
			|=> out_flags == $past(in_flags) && crc_replace)
		else $error("crc-only altered flags");

	AST_BYPASS_PASS: assert property (@(posedge clk) // R20
		disable iff (!rst_sync_n || !clk_en)
		(packet_send && bypass) |=> out_flags == $past(in_flags)
			&& !crc_replace)
		else $error("bypass modified the packet");

	AST_BYPASS_READ: assert property (@(posedge clk) // R21
		disable iff (!rst_sync_n || !clk_en)
		(port_read_nwrite && !fwd_on_r && bypass && !in_out_sel_r
			&& group_sel_in != SEL_CTL) |=> flag_lines_out == '0)
		else $error("bypass outgoing read not zero");

endmodule

/* File: verification/efp_ctl_model.sv */
// Controller model for the flag port and the shared wire levels.
`timescale 1ns/10ps
module efp_ctl_model
	import efp_pkg::*;
(
	// Clock.
	input wire logic clk,
	// Device side of the shared wires.
	input wire logic [GRP_W-1:0] dev_fl,
	input wire logic dev_fl_oe_n,
	input wire logic [1:0] dev_sel,
	input wire logic dev_sel_oe_n,
	// Levels seen by the device.
	output logic dir,
	output logic fwd,
	output logic [1:0] sel_w,
	output logic [GRP_W-1:0] fl_w
);
	logic [1:0] sel; // Select that the controller drives.
	logic drv; // High while the controller drives the flags.
	logic [GRP_W-1:0] pv; // Flag value that the controller drives.
	logic [GRP_W-1:0] last; // Last resolved flag level.

	// ====================================
	// Wire resolution
	// ====================================
	// A wire nobody drives has no pull, so it shows the inverse of its
	// last level instead of a value the simulator would settle for us.
	assign fl_w = drv ? pv : (!dev_fl_oe_n ? dev_fl : ~last);
	// The select goes straight across, adding no link latency.
	assign sel_w = !dev_sel_oe_n ? dev_sel : sel;

	// Remember the wire level for the undriven pattern.
	always @(posedge clk) begin
		last <= fl_w;
	end

	// Idle in read mode, which is the safe parking state of the port.
	initial begin
		{dir, fwd, drv} = 3'b100;
		sel = SEL_AP;
		pv = '0;
		last = '0;
	end

	// ====================================
	// Controller cycles
	// ====================================
	// Write one group; the flags follow one clock after direction falls.
	task automatic wr_grp(input logic [1:0] s, input logic [4:0] v,
		output logic oe);
		dir <= 1'b0;
		sel <= s;
		@(posedge clk);
		drv <= 1'b1;
		pv <= v;
		#1 oe = dev_fl_oe_n;
		@(posedge clk);
		dir <= 1'b1;
		drv <= 1'b0;
		@(posedge clk);
	endtask

	// Present one read select for one sampling edge.
	task automatic rd_sel(input logic [1:0] s);
		dir <= 1'b1;
		sel <= s;
		@(posedge clk);
	endtask

	// Direction is high a clock before forwarding changes.
	task automatic fwd_set(input logic on);
		dir <= 1'b1;
		@(posedge clk);
		fwd <= on;
		@(posedge clk);
	endtask
endmodule

/* File: verification/efp_flag_port_tb.sv */
// Self-checking bench for the error flag port block.
`timescale 1ns/10ps
module efp_flag_port_tb
	import efp_pkg::*;
;
	// Write rows: select, value and the outgoing flags they give.
	typedef struct packed {
		logic [1:0] s;
		logic [4:0] v;
		logic [14:0] e;
	} efp_row_t;
	localparam efp_row_t ROWS [3] = '{'{SEL_FF, 5'h15, 15'h0015},
		'{SEL_AP, 5'h0A, 15'h0140}, '{SEL_ANC, 5'h1F, 15'h7C00}};
	// Forwarded select order.
	localparam logic [1:0] FS [3] = '{SEL_AP, SEL_FF, SEL_ANC};
	logic clk, reset_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic dir, fwd, gs_oe_n, fl_oe_n, crc_only, rx_tx_sel, e, oe;
	logic [1:0] sel_w, gs_out, in_val, out_val, s, g;
	logic [4:0] fl_w, fl_out, x;
	logic packet_processing_bypass, prx, psend, chk_err, crc_rep;
	logic [14:0] in_flags, calc, out_flags;
	int error_cnt, compares, i;

	// ====================================
	// Design and controller
	// ====================================
	efp_flag_port efp_flag_port_inst (.clk(clk), .reset_n(reset_n),
		.clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .port_read_nwrite(dir), .flag_forward(fwd),
		.group_sel_in(sel_w), .group_sel_out(gs_out),
		.group_sel_oe_n(gs_oe_n), .flag_lines_in(fl_w),
		.flag_lines_out(fl_out), .flag_lines_oe_n(fl_oe_n),
		.crc_only(crc_only), .rx_tx_sel(rx_tx_sel),
		.packet_processing_bypass(packet_processing_bypass),
		.packet_received(prx), .packet_send(psend), .in_flags(in_flags),
		.in_validity(in_val), .calc_flags(calc),
		.packet_checksum_error(chk_err), .out_flags(out_flags),
		.out_validity(out_val), .crc_replace(crc_rep));
	efp_ctl_model efp_ctl_model_inst (.clk(clk), .dev_fl(fl_out),
		.dev_fl_oe_n(fl_oe_n), .dev_sel(gs_out), .dev_sel_oe_n(gs_oe_n),
		.dir(dir), .fwd(fwd), .sel_w(sel_w), .fl_w(fl_w));

	// ====================================
	// Clock, helpers and watchdog
	// ====================================
	// The 40 MHz clock.
	initial clk = 1'b0;
	always #12.5 clk = ~clk;

	// Compare one value and count it.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h",
				$time, got, exp);
		end
	endtask

	// One APB transfer; the answer is taken when pready is sampled.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer.
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	// Build one outgoing packet.
	task automatic send();
		psend <= 1'b1;
		@(posedge clk);
		psend <= 1'b0;
		@(posedge clk);
	endtask

	// Print the counts and the verdict, then stop.
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// A hang counts as a mismatch; the tests need about 115 clocks.
	initial begin
		#100000;
		error_cnt++;
		end_sim();
	end

	// ====================================
	// Tests
	// ====================================
	initial begin
		{reset_n, psel, penable, pwrite, crc_only, rx_tx_sel} = '0;
		{packet_processing_bypass, prx, psend} = '0;
		{paddr, pwdata, calc} = '0;
		{in_flags, in_val, chk_err} = {15'h2B5D, 2'h2, 1'b1};
		repeat (8) @(posedge clk);
		chk(32'({gs_oe_n, fl_oe_n}), 32'h3);
		chk(32'({gs_out, fl_out}), 32'h20);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(q, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		chk({q[30:0], e}, 32'h1);
		$display("test reset done");
		for (i = 0; i < 3; i++) begin
			efp_ctl_model_inst.wr_grp(ROWS[i].s, ROWS[i].v, oe);
			chk(32'(oe), 32'h1);
			send();
			chk(32'(out_flags), 32'(ROWS[i].e));
		end
		send();
		chk(32'(out_flags), 32'h0);
		apb(1'b1, ADDR_HOST_OVR, 32'h7FFF);
		apb(1'b1, ADDR_CTRL, 32'h2);
		efp_ctl_model_inst.wr_grp(SEL_FF, 5'h00, oe);
		send();
		chk(32'(out_flags), 32'h7FE0);
		apb(1'b1, ADDR_CTRL, 32'h0);
		$display("test port write done");
		// Incoming flags are chosen for reads by the latched select.
		efp_ctl_model_inst.wr_grp(SEL_CTL, 5'h10, oe);
		for (i = 0; i < 4; i++) begin
			efp_ctl_model_inst.rd_sel(2'(i));
			#1;
			x = (i == 3) ? 5'h1A : in_flags[i*5 +: 5];
			chk(32'({fl_oe_n, fl_out}), 32'(x));
			@(posedge clk);
		end
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(32'(q[STAT_INOUT_BIT]), 32'h1);
		efp_ctl_model_inst.wr_grp(SEL_CTL, 5'h00, oe);
		$display("test port read done");
		crc_only <= 1'b1;
		calc <= 15'h4583;
		for (i = 0; i < 2; i++) begin
			rx_tx_sel <= i[0];
			send();
			chk(32'(out_flags), 32'(in_flags));
			chk(32'({crc_rep, out_val}), 32'(i == 0 ? 4 : 6));
		end
		// Receive mode without crc-only merges the computed flags.
		crc_only <= 1'b0;
		send();
		chk(32'(out_flags), 32'h6FDF);
		rx_tx_sel <= 1'b0;
		$display("test crc only done");
		efp_ctl_model_inst.fwd_set(1'b1);
		repeat (2) @(posedge clk);
		#1;
		chk(32'({gs_oe_n, fl_oe_n, gs_out}), 32'(SEL_AP));
		@(posedge clk);
		prx <= 1'b1;
		@(posedge clk);
		prx <= 1'b0;
		// The cycle after the packet edge still shows the idle value.
		@(posedge clk);
		for (i = 0; i < 8; i++) begin
			#1;
			g = (i < 6) ? FS[i/2] : SEL_ANC;
			s = (i < 6) ? g : SEL_AP;
			x = calc[g*5 +: 5];
			chk(32'({gs_out, fl_out}), 32'({s, x}));
			@(posedge clk);
		end
		$display("test forward done");
		packet_processing_bypass <= 1'b1;
		prx <= 1'b1;
		@(posedge clk);
		prx <= 1'b0;
		repeat (8) @(posedge clk);
		#1;
		chk(32'(fl_out), 32'h0);
		efp_ctl_model_inst.fwd_set(1'b0);
		@(posedge clk);
		efp_ctl_model_inst.rd_sel(SEL_AP);
		#1;
		chk(32'(fl_out), 32'h0);
		@(posedge clk);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(q & 32'h1FFFF, 32'h10000);
		apb(1'b0, ADDR_IN_FLAGS, 32'h0);
		chk(q, 32'(in_flags));
		send();
		chk(32'({crc_rep, out_flags}), 32'(in_flags));
		packet_processing_bypass <= 1'b0;
		apb(1'b1, ADDR_CTRL, 32'h1);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(32'(q[STAT_BYPASS_BIT]), 32'h1);
		$display("test bypass done");
		end_sim();
	end
endmodule
